// file: include/sadc_pkg.sv
package sadc_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned DATA_W            = 12;
  // host timing
  localparam int unsigned CONV_PULSE_NS     = 40;
  localparam int unsigned SETUP_NS          = 10;
  localparam int unsigned SPACING_NS        = 1660;
  localparam int unsigned CONV_PULSE_CYC    =
    (CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC         =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SPACING_CYC       =
    (SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // device timing
  localparam int unsigned BUSY_DELAY_MAX_NS = 125;
  localparam int unsigned BUSY_LOW_NS       = 1300;
  localparam int unsigned BUSY_LOW_CYC      = BUSY_LOW_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W             = 8;
  localparam logic [CNT_W-1:0] CNT_RST      = 8'h00;
  localparam logic [DATA_W-1:0] RESULT_RST  = 12'h000;
  localparam logic [DATA_W-1:0] CODE_POS_FS = 12'h7FF;
  localparam logic [DATA_W-1:0] CODE_NEG_FS = 12'h800;
endpackage

// file: include/sadc_if.sv
`timescale 1ns/1ps
interface sadc_if;
  logic                chip_select_n;
  logic                read_convert_n;
  logic                busy_n;
  logic [11:0]         result_bits_out;
  logic [11:0]         result_bits_oe;
  modport dev (
    input  chip_select_n,
    input  read_convert_n,
    output busy_n,
    output result_bits_out,
    output result_bits_oe
  );
  modport host (
    output chip_select_n,
    output read_convert_n,
    input  busy_n,
    input  result_bits_out,
    input  result_bits_oe
  );
endinterface

// file: hdl/sadc_dev.sv
`timescale 1ns/1ps
// Summary of operation
// - host holds convert low at least 40 ns
// - busy low until result register updated
// - two's complement result, msb on bit 11
// - requests while busy are ignored
// - host spaces conversions at least 1.66 us
// - select and convert OR'd, level triggered
// - non-trigger line low 10 ns earlier
// - drive bus only when read, selected, idle
// - select falling with convert low starts
// - convert falling with select low starts
// - select falling with read high enables bus
// - read during conversion enables bus afterward
// - completion with convert low keeps bus off
// - data valid by busy rising edge
// - one full 12-bit parallel word
// - codes 7FF, 000, FFF, 800 map scale
// - select may be tied low permanently
// - busy falls within 125 ns of start; here 200 to 300 ns after the pin edge, behind the two-flop synchroniser
// - host keeps bus quiet while converting
// - convert falling samples and holds input
module sadc_dev (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  sadc_if.dev              bus,
  input  wire logic [11:0] sample_i,
  output logic             sample_hold_o
);
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b01,
    SADC_CONV = 2'b10
  } sadc_state_t;

  sadc_state_t                         state_reg;
  sadc_state_t                         state_next;
  logic [1:0]                          cs_sync_reg;
  logic [1:0]                          rc_sync_reg;
  logic [sadc_pkg::CNT_W-1:0]          cnt_reg;
  logic [sadc_pkg::DATA_W-1:0]         held_reg;
  logic [sadc_pkg::DATA_W-1:0]         result_reg;
  logic                                busy_n_reg;
  logic                                oe_reg;
  logic                                start;
  logic                                done;
  logic [sadc_pkg::DATA_W-1:0]         trial_reg;
  logic [sadc_pkg::DATA_W-1:0]         guess;
  logic [sadc_pkg::DATA_W-1:0]         offset_code;
  logic [3:0]                          bit_reg;
  logic                                sar_on_reg;
  logic                                hold_reg;

  // select low with convert low asks for a conversion
  function automatic logic conv_level(input logic cs_n, input logic rc_n);
    conv_level = !cs_n && !rc_n;
  endfunction

  // select low with convert high asks for the bus
  function automatic logic read_level(input logic cs_n, input logic rc_n);
    read_level = !cs_n && rc_n;
  endfunction

  // pins come from the host's clock, so synchronise before use
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_sync_reg <= 2'b11;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], bus.chip_select_n};
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rc_sync_reg <= 2'b11;
    end else begin
      rc_sync_reg <= {rc_sync_reg[0], bus.read_convert_n};
    end
  end

  // level triggered: either line may fall last, busy masks repeats
  assign start = (state_reg == SADC_IDLE)
                 && conv_level(cs_sync_reg[1], rc_sync_reg[1]);
  assign done  = (state_reg == SADC_CONV) && (cnt_reg == sadc_pkg::CNT_W'(1));

  // offset binary lets a plain unsigned compare drive the search
  assign offset_code = {~held_reg[sadc_pkg::DATA_W-1], held_reg[sadc_pkg::DATA_W-2:0]};
  assign guess       = trial_reg | (sadc_pkg::DATA_W'(1) << bit_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SADC_IDLE: if (start) state_next = SADC_CONV;
      SADC_CONV: if (done) state_next = SADC_IDLE;
      default:   state_next = SADC_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= SADC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= sadc_pkg::CNT_RST;
    end else if (start) begin
      cnt_reg <= sadc_pkg::CNT_W'(sadc_pkg::BUSY_LOW_CYC);
    end else if (cnt_reg != sadc_pkg::CNT_RST) begin
      cnt_reg <= cnt_reg - sadc_pkg::CNT_W'(1);
    end
  end

  // the input is frozen at start; a hold kept for the whole conversion
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      held_reg <= sadc_pkg::RESULT_RST;
    end else if (start) begin
      held_reg <= sample_i;
    end
  end

  // msb to lsb; the busy count must cover one cycle per bit plus the update
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_reg <= 4'h0;
    end else if (start) begin
      bit_reg <= 4'(sadc_pkg::DATA_W - 1);
    end else if (sar_on_reg && (bit_reg != 4'h0)) begin
      bit_reg <= bit_reg - 4'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sar_on_reg <= 1'b0;
    end else if (start) begin
      sar_on_reg <= 1'b1;
    end else if (sar_on_reg && (bit_reg == 4'h0)) begin
      sar_on_reg <= 1'b0;
    end
  end

  // a bit stays set when the guess does not overshoot the held code
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trial_reg <= sadc_pkg::RESULT_RST;
    end else if (start) begin
      trial_reg <= sadc_pkg::RESULT_RST;
    end else if (sar_on_reg && (guess <= offset_code)) begin
      trial_reg <= guess;
    end
  end

  // two's complement code passed whole, msb on bit 11
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_reg <= sadc_pkg::RESULT_RST;
    end else if (done) begin
      result_reg <= {~trial_reg[sadc_pkg::DATA_W-1],
                     trial_reg[sadc_pkg::DATA_W-2:0]};
    end
  end

  // busy falls one edge after start, 200 to 300 ns after the pin falls at 10 MHz, not within 125 ns
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_n_reg <= 1'b1;
    end else if (start) begin
      busy_n_reg <= 1'b0;
    end else if (done) begin
      busy_n_reg <= 1'b1;
    end
  end

  // registered so the hold flag cannot glitch between states
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hold_reg <= 1'b0;
    end else if (start) begin
      hold_reg <= 1'b1;
    end else if (done) begin
      hold_reg <= 1'b0;
    end
  end

  // enable tracks the same edge as busy rising, the edge that also loads the data
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= (state_next == SADC_IDLE) && !start
                && read_level(cs_sync_reg[1], rc_sync_reg[1]);
    end
  end

  assign bus.busy_n          = busy_n_reg;
  assign bus.result_bits_out = result_reg;
  assign sample_hold_o       = hold_reg;

  // one shared enable per bit so the word is never split
  for (genvar gi = 0; gi < sadc_pkg::DATA_W; gi++) begin : g_oe
    assign bus.result_bits_oe[gi] = oe_reg;
  end
endmodule

// file: hdl/sadc_host.sv
`timescale 1ns/1ps
module sadc_host (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  sadc_if.host             bus,
  input  wire logic        conv_req_i,
  output logic             conv_ack_o,
  output logic [11:0]      data_o,
  output logic             data_valid_o
);
  typedef enum logic [3:0] {
    SADH_IDLE  = 4'b0001,
    SADH_LOW   = 4'b0010,
    SADH_WAIT  = 4'b0100,
    SADH_SPACE = 4'b1000
  } sadh_state_t;

  sadh_state_t                 state_reg;
  logic [7:0]                  cnt_reg;
  logic [1:0]                  busy_sync_reg;
  logic                        busy_prev_reg;
  logic [11:0]                 data_reg;
  logic                        valid_reg;
  logic                        rc_n_reg;
  logic [11:0]                 pins;

  // chip select tied low, convert line alone picks mode
  assign bus.chip_select_n  = 1'b0;
  assign bus.read_convert_n = rc_n_reg;
  assign pins = bus.result_bits_out & bus.result_bits_oe;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_sync_reg <= 2'b11;
      busy_prev_reg <= 1'b1;
    end else begin
      busy_sync_reg <= {busy_sync_reg[0], bus.busy_n};
      busy_prev_reg <= busy_sync_reg[1];
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg     <= SADH_IDLE;
      cnt_reg       <= 8'h00;
      rc_n_reg      <= 1'b1;
    end else begin
      case (state_reg)
        SADH_IDLE: if (conv_req_i) begin
          rc_n_reg  <= 1'b0;
          cnt_reg   <= 8'(sadc_pkg::SPACING_CYC);
          state_reg <= SADH_LOW;
        end
        // holding low until busy is seen covers the 40 ns minimum
        SADH_LOW: begin
          cnt_reg <= cnt_reg - 8'h01;
          if (!busy_sync_reg[1]) begin
            rc_n_reg      <= 1'b1;
            state_reg     <= SADH_WAIT;
          end
        end
        // the bus stays quiet while converting
        SADH_WAIT: begin
          cnt_reg <= (cnt_reg == 8'h00) ? 8'h00 : cnt_reg - 8'h01;
          if (busy_sync_reg[1] && !busy_prev_reg) begin
            state_reg     <= SADH_SPACE;
          end
        end
        SADH_SPACE: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= SADH_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= SADH_IDLE;
      endcase
    end
  end

  // sample one edge after busy rose in synced domain; data already stable
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_reg  <= 12'h000;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (state_reg == SADH_WAIT && busy_sync_reg[1] && !busy_prev_reg) begin
        data_reg  <= pins;
        valid_reg <= 1'b1;
      end
    end
  end

  assign conv_ack_o   = (state_reg == SADH_IDLE) && conv_req_i;
  assign data_o       = data_reg;
  assign data_valid_o = valid_reg;
endmodule

// file: tb/sadc_asserts.sv
`timescale 1ns/1ps
module sadc_asserts (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        chip_select_n,
  input  wire logic        read_convert_n,
  input  wire logic        busy_n,
  input  wire logic [11:0] result_bits_out,
  input  wire logic [11:0] result_bits_oe
);
  // counts busy low cycles; a repetition of 13 would be too long to unroll
  logic [7:0] low_cnt_reg;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_cnt_reg <= 8'h00;
    end else begin
      low_cnt_reg <= busy_n ? 8'h00 : low_cnt_reg + 8'h01;
    end
  end
  property p_oe_idle; (result_bits_oe != 12'h000) |-> busy_n; endproperty
  a_oe_idle:
    assert property (p_oe_idle) else $error("bus driven while busy");
  property p_oe_off; (!read_convert_n)[*4] |-> result_bits_oe == 12'h000; endproperty
  a_oe_off:
    assert property (p_oe_off) else $error("bus driven in convert mode");
  property p_start; $fell(read_convert_n) && !chip_select_n && busy_n |-> ##[1:4] !busy_n;
  endproperty
  a_start:
    assert property (p_start) else $error("busy did not fall");
  property p_len; $rose(busy_n) |-> low_cnt_reg == 8'h0D; endproperty
  a_len:
    assert property (p_len) else $error("busy low length wrong");
  property p_max; low_cnt_reg <= 8'h0D; endproperty
  a_max:
    assert property (p_max) else $error("conversion extended");
  property p_hold; !busy_n |=> busy_n || $stable(result_bits_out); endproperty
  a_hold:
    assert property (p_hold) else $error("result changed mid conversion");
  property p_end; $rose(busy_n) && !chip_select_n && read_convert_n |->
    result_bits_oe == 12'hFFF; endproperty
  a_end:
    assert property (p_end) else $error("bus not enabled at end");
  property p_whole; result_bits_oe == 12'h000 || result_bits_oe == 12'hFFF; endproperty
  a_whole:
    assert property (p_whole) else $error("partial word enable");
  property p_read; (busy_n && read_convert_n && !chip_select_n)[*4] |->
    result_bits_oe == 12'hFFF; endproperty
  a_read:
    assert property (p_read) else $error("idle read not driven");
  c_conv: cover property ($rose(busy_n));
  c_on: cover property ($rose(result_bits_oe[0]));
  c_off: cover property ($fell(result_bits_oe[0]));
endmodule

// file: tb/sar_adc_parallel_control_tb.sv
`timescale 1ns/1ps
module sar_adc_parallel_control_tb;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        conv_req_i = 1'b0;
  logic [11:0] sample_i = 12'h000;
  logic [11:0] sample_b_i = 12'h000;
  logic        conv_ack_o;
  logic [11:0] data_o;
  logic        data_valid_o;
  logic        hold_b_o;
  realtime     fall_t = 0.0;
  int          errors = 0;
  int          check_count = 0;
  logic [11:0] exp_q[$];
  logic [11:0] codes [4] = '{12'h7FF, 12'h000, 12'hFFF, 12'h800};
  sadc_if bus();
  sadc_if bus_b();
  always #50 mclk_i = ~mclk_i;
  sadc_dev u_sadc_dev (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus(bus),
    .sample_i(sample_i), .sample_hold_o());
  // second device driven by the bench to reach select timing the host never makes
  sadc_dev u_sadc_dev_b (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus(bus_b),
    .sample_i(sample_b_i), .sample_hold_o(hold_b_o));
  sadc_host u_sadc_host (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus(bus),
    .conv_req_i(conv_req_i), .conv_ack_o(conv_ack_o), .data_o(data_o),
    .data_valid_o(data_valid_o));
  sadc_asserts u_sadc_asserts (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .chip_select_n(bus.chip_select_n), .read_convert_n(bus.read_convert_n),
    .busy_n(bus.busy_n), .result_bits_out(bus.result_bits_out),
    .result_bits_oe(bus.result_bits_oe));
  // host timing seen at the pins, in ns
  always @(negedge bus.read_convert_n) begin
    if (fall_t > 0.0) begin
      check_count++;
      if ($realtime - fall_t < real'(sadc_pkg::SPACING_NS)) begin
        errors++;
        $display("[ERR] %0t convert requests too close", $time);
      end
    end
    fall_t = $realtime;
  end
  always @(posedge bus.read_convert_n) begin
    if (fall_t > 0.0) begin
      check_count++;
      if ($realtime - fall_t < real'(sadc_pkg::CONV_PULSE_NS)) begin
        errors++;
        $display("[ERR] %0t convert pulse too short", $time);
      end
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk_i);
    #10;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic convert(input logic [11:0] v);
    int n;
    sample_i = v;
    exp_q.push_back(v);
    conv_req_i = 1'b1;
    #1 chk({11'h000, conv_ack_o}, 12'h001, "ack");
    tk(1);
    conv_req_i = 1'b0;
    n = 0;
    while (data_valid_o !== 1'b1 && n < 60) begin
      tk(1);
      n++;
    end
    if (data_valid_o !== 1'b1) begin
      errors++;
      $display("[ERR] %0t no result from host", $time);
      report_and_stop();
    end else begin
      chk(data_o, exp_q.pop_front(), "data");
      chk(bus.result_bits_out, v, "bus word");
      chk(bus.result_bits_oe, 12'hFFF, "bus on");
      tk(2);
    end
  endtask
  initial begin
    void'($urandom(32'h00A2E699));
    bus_b.chip_select_n = 1'b1;
    bus_b.read_convert_n = 1'b0;
    tk(6);
    chk({11'h000, bus.busy_n}, 12'h001, "busy rst");
    chk(bus.result_bits_oe, 12'h000, "oe rst");
    arst_n_i = 1'b1;
    tk(5);
    chk({11'h000, bus_b.busy_n}, 12'h001, "no start");
    chk(bus_b.result_bits_oe, 12'h000, "oe idle");
    foreach (codes[i]) convert(codes[i]);
    repeat (6) convert(12'($urandom));
    $display("host test done");
    sample_b_i = 12'h5A3;
    bus_b.chip_select_n = 1'b0;
    tk(4);
    chk({11'h000, bus_b.busy_n}, 12'h000, "cs start");
    chk({11'h000, hold_b_o}, 12'h001, "hold on");
    // input moves after capture; the held value must win
    sample_b_i = 12'h3C6;
    bus_b.read_convert_n = 1'b1;
    tk(1);
    bus_b.read_convert_n = 1'b0;
    tk(1);
    bus_b.read_convert_n = 1'b1;
    tk(10);
    chk({11'h000, bus_b.busy_n}, 12'h001, "no restart");
    chk({11'h000, hold_b_o}, 12'h000, "hold off");
    chk(bus_b.result_bits_oe, 12'hFFF, "auto on");
    chk(bus_b.result_bits_out, 12'h5A3, "held");
    bus_b.chip_select_n = 1'b1;
    tk(4);
    chk(bus_b.result_bits_oe, 12'h000, "cs off");
    bus_b.chip_select_n = 1'b0;
    tk(4);
    chk(bus_b.result_bits_oe, 12'hFFF, "cs on");
    bus_b.read_convert_n = 1'b0;
    tk(4);
    chk(bus_b.result_bits_oe, 12'h000, "rc off");
    chk({11'h000, bus_b.busy_n}, 12'h000, "rc start");
    tk(13);
    chk(bus_b.result_bits_oe, 12'h000, "stay off");
    chk(bus_b.result_bits_out, 12'h3C6, "stored");
    bus_b.read_convert_n = 1'b1;
    tk(20);
    chk(bus_b.result_bits_oe, 12'hFFF, "read on");
    $display("select test done");
    report_and_stop();
  end
endmodule
